/* logic/dmfm_top.sv */
/*
 Drive motion fault monitor: stall supervision, fieldbus command checks, cable,
 missed command and bus-off faults, latched with an AHB-Lite register file.
 Assumes current and velocity samples synchronous to hclk, single word transfers.
*/
// Design decisions made here: the AHB-Lite slave port and the register offsets.
// How it works
// - Stall condition: current over continuous rating, over 0.9 ceiling, speed below threshold.
// - Stall held longer than limit raises fault 59, disables drive, no active disable.
// - Target breaking velocity limit is rejected, fault 30, drive disabled.
// - Target breaking acceleration or deceleration limit is rejected, fault 66, drive disabled.
// - Lost controller connection raises fault 65 and disables drive.
// - Three consecutive missing target commands raise fault 69 and disable drive.
// - Bus-off stops packet traffic, raises fault 88, disables drive.
// - Mask object bit suppresses the bus-off fault.
`timescale 1ns/100ps
`default_nettype none
module dmfm_top (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Drive measurements
    input wire logic [15:0] meas_current,
    input wire logic [15:0] meas_velocity,
    // Fieldbus side
    input wire logic cmd_valid,
    input wire logic [31:0] cmd_target,
    input wire logic cable_present,
    input wire logic can_bus_off,
    // Drive control
    output logic drive_enable,
    output logic active_disable,
    output logic can_traffic_en,
    output logic cmd_accept,
    output logic [7:0] fault_code,
    output logic irq
);
    // ****************************************
    // Registers
    // ****************************************
    logic [5:0] status_ff;
    logic [5:0] mask_ff;
    logic enable_req_ff;
    logic busoff_mask_ff;
    logic [15:0] cont_cur_ff;
    logic [15:0] cur_ceil_ff;
    logic [15:0] low_speed_ff;
    logic [31:0] stall_lim_ff;
    logic [15:0] vel_lim_ff;
    logic [15:0] acc_lim_ff;
    logic [31:0] cmd_period_ff;
    logic [31:0] period_cnt_ff;
    logic [1:0] miss_cnt_ff;
    logic drive_enable_ff;
    logic active_disable_ff;
    logic can_traffic_ff;
    logic cmd_accept_ff;
    logic [7:0] fault_code_ff;
    logic irq_ff;
    logic [31:0] hrdata_ff;
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    // ****************************************
    // Bus decode
    // ****************************************
    logic addr_phase;
    logic [7:0] rd_addr;
    logic wr_go;
    logic [5:0] clr_bits;
    logic [5:0] events;
    logic stall_cond;
    logic stall_expired;
    logic vel_bad;
    logic acc_bad;
    logic accepted;
    logic miss_tick;
    logic [20:0] ceil_scaled;
    logic [20:0] cur_scaled;
    logic [7:0] nxt_fault_code;

    assign addr_phase = hsel && hready && htrans[1];
    assign rd_addr = haddr[7:0];
    assign wr_go = wr_pend_ff;
    assign clr_bits = (wr_go && wr_addr_ff == dmfm_pkg::ADDR_STATUS) ? hwdata[5:0] : 6'h00;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_ff <= haddr[7:0];
            end
        end
    end

    // Configuration writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_ff <= 6'h00;
            enable_req_ff <= 1'b0;
            busoff_mask_ff <= 1'b0;
            cont_cur_ff <= dmfm_pkg::RST_CONT_CUR;
            cur_ceil_ff <= dmfm_pkg::RST_CUR_CEIL;
            low_speed_ff <= dmfm_pkg::RST_LOW_SPEED;
            stall_lim_ff <= dmfm_pkg::RST_STALL_LIM;
            vel_lim_ff <= dmfm_pkg::RST_VEL_LIM;
            acc_lim_ff <= dmfm_pkg::RST_ACC_LIM;
            cmd_period_ff <= dmfm_pkg::RST_CMD_PERIOD;
        end else if (wr_go) begin
            unique case (wr_addr_ff)
                dmfm_pkg::ADDR_CTRL: enable_req_ff <= hwdata[0];
                dmfm_pkg::ADDR_MASK: mask_ff <= hwdata[5:0];
                dmfm_pkg::ADDR_CONT_CUR: cont_cur_ff <= hwdata[15:0];
                dmfm_pkg::ADDR_CUR_CEIL: cur_ceil_ff <= hwdata[15:0];
                dmfm_pkg::ADDR_LOW_SPEED: low_speed_ff <= hwdata[15:0];
                dmfm_pkg::ADDR_STALL_LIM: stall_lim_ff <= hwdata;
                dmfm_pkg::ADDR_VEL_LIM: vel_lim_ff <= hwdata[15:0];
                dmfm_pkg::ADDR_ACC_LIM: acc_lim_ff <= hwdata[15:0];
                dmfm_pkg::ADDR_CMD_PERIOD: cmd_period_ff <= hwdata;
                dmfm_pkg::ADDR_BUSOFF_OBJ: busoff_mask_ff <= hwdata[0];
                default: ;
            endcase
        end
    end

    // Read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            unique case (rd_addr)
                dmfm_pkg::ADDR_CTRL: hrdata_ff <= {31'h0, enable_req_ff};
                dmfm_pkg::ADDR_STATUS: hrdata_ff <= {26'h0, status_ff};
                dmfm_pkg::ADDR_MASK: hrdata_ff <= {26'h0, mask_ff};
                dmfm_pkg::ADDR_CONT_CUR: hrdata_ff <= {16'h0, cont_cur_ff};
                dmfm_pkg::ADDR_CUR_CEIL: hrdata_ff <= {16'h0, cur_ceil_ff};
                dmfm_pkg::ADDR_LOW_SPEED: hrdata_ff <= {16'h0, low_speed_ff};
                dmfm_pkg::ADDR_STALL_LIM: hrdata_ff <= stall_lim_ff;
                dmfm_pkg::ADDR_VEL_LIM: hrdata_ff <= {16'h0, vel_lim_ff};
                dmfm_pkg::ADDR_ACC_LIM: hrdata_ff <= {16'h0, acc_lim_ff};
                dmfm_pkg::ADDR_CMD_PERIOD: hrdata_ff <= cmd_period_ff;
                dmfm_pkg::ADDR_FAULT_CODE: hrdata_ff <= {24'h0, fault_code_ff};
                dmfm_pkg::ADDR_BUSOFF_OBJ: hrdata_ff <= {31'h0, busoff_mask_ff};
                default: hrdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // ****************************************
    // Stall supervision
    // ****************************************
    always_comb begin
        cur_scaled = 21'(meas_current) * 21'(dmfm_pkg::CEIL_DEN);
        ceil_scaled = 21'(cur_ceil_ff) * 21'(dmfm_pkg::CEIL_NUM);
        stall_cond = (meas_current > cont_cur_ff) && (cur_scaled > ceil_scaled)
                     && (meas_velocity < low_speed_ff);
    end

    dmfm_persist_timer u_stall_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .cond(stall_cond),
        .limit(stall_lim_ff),
        .expired(stall_expired)
    );
    // ****************************************
    // Command checks
    // ****************************************
    dmfm_cmd_check u_cmd_check (
        .hclk(hclk),
        .hresetn(hresetn),
        .cmd_valid(cmd_valid && can_traffic_ff),
        .cmd_target(cmd_target),
        .vel_limit(vel_lim_ff),
        .acc_limit(acc_lim_ff),
        .vel_bad(vel_bad),
        .acc_bad(acc_bad),
        .accepted(accepted)
    );

    // Missed command watchdog, runs while the drive is enabled
    assign miss_tick = drive_enable_ff && (period_cnt_ff >= cmd_period_ff - 32'h0000_0001);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            period_cnt_ff <= 32'h0000_0000;
            miss_cnt_ff <= 2'h0;
        end else if (!drive_enable_ff || (cmd_valid && can_traffic_ff)) begin
            period_cnt_ff <= 32'h0000_0000;
            miss_cnt_ff <= 2'h0;
        end else if (miss_tick) begin
            period_cnt_ff <= 32'h0000_0000;
            if (miss_cnt_ff != dmfm_pkg::MISS_LIMIT) begin
                miss_cnt_ff <= miss_cnt_ff + 2'h1;
            end
        end else begin
            period_cnt_ff <= period_cnt_ff + 32'h0000_0001;
        end
    end
    // ****************************************
    // Fault latch
    // ****************************************
    always_comb begin
        events = 6'h00;
        events[dmfm_pkg::BIT_STALL] = stall_expired;
        events[dmfm_pkg::BIT_VEL] = vel_bad;
        events[dmfm_pkg::BIT_ACC] = acc_bad;
        events[dmfm_pkg::BIT_CABLE] = !cable_present;
        events[dmfm_pkg::BIT_MISSED] = miss_tick && (miss_cnt_ff == dmfm_pkg::MISS_LIMIT - 2'h1);
        events[dmfm_pkg::BIT_BUSOFF] = can_bus_off && !busoff_mask_ff;
    end

    // Set wins over write-one clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_ff <= 6'h00;
        end else begin
            status_ff <= (status_ff & ~clr_bits) | events;
        end
    end

    always_comb begin
        nxt_fault_code = 8'h00;
        if (status_ff[dmfm_pkg::BIT_BUSOFF]) nxt_fault_code = dmfm_pkg::FLT_BUSOFF;
        if (status_ff[dmfm_pkg::BIT_MISSED]) nxt_fault_code = dmfm_pkg::FLT_MISSED;
        if (status_ff[dmfm_pkg::BIT_CABLE]) nxt_fault_code = dmfm_pkg::FLT_CABLE;
        if (status_ff[dmfm_pkg::BIT_ACC]) nxt_fault_code = dmfm_pkg::FLT_ACC;
        if (status_ff[dmfm_pkg::BIT_VEL]) nxt_fault_code = dmfm_pkg::FLT_VEL;
        if (status_ff[dmfm_pkg::BIT_STALL]) nxt_fault_code = dmfm_pkg::FLT_STALL;
    end
    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_enable_ff <= 1'b0;
            active_disable_ff <= 1'b0;
            can_traffic_ff <= 1'b1;
            cmd_accept_ff <= 1'b0;
            fault_code_ff <= 8'h00;
            irq_ff <= 1'b0;
        end else begin
            drive_enable_ff <= enable_req_ff && (status_ff == 6'h00) && (events == 6'h00);
            active_disable_ff <= |status_ff[5:1];
            can_traffic_ff <= !can_bus_off;
            cmd_accept_ff <= accepted;
            fault_code_ff <= nxt_fault_code;
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    assign drive_enable = drive_enable_ff;
    assign active_disable = active_disable_ff;
    assign can_traffic_en = can_traffic_ff;
    assign cmd_accept = cmd_accept_ff;
    assign fault_code = fault_code_ff;
    assign irq = irq_ff;
    // ****************************************
    // Checks
    // ****************************************
    chk_stall_disable: assert property (@(posedge hclk) disable iff (!hresetn)
        stall_expired |=> status_ff[dmfm_pkg::BIT_STALL] ##1 !drive_enable_ff)
        else $error("stall did not latch and disable");
    chk_vel_reject: assert property (@(posedge hclk) disable iff (!hresetn)
        vel_bad |-> !accepted ##1 status_ff[dmfm_pkg::BIT_VEL])
        else $error("velocity breach not rejected");
    chk_acc_reject: assert property (@(posedge hclk) disable iff (!hresetn)
        acc_bad |-> !accepted ##1 status_ff[dmfm_pkg::BIT_ACC] ##1 !drive_enable_ff)
        else $error("acceleration breach not rejected");
    chk_cable_fault: assert property (@(posedge hclk) disable iff (!hresetn)
        !cable_present |=> status_ff[dmfm_pkg::BIT_CABLE])
        else $error("cable loss not latched");
    chk_miss_count: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(status_ff[dmfm_pkg::BIT_MISSED]) |-> $past(miss_cnt_ff) == 2'h2)
        else $error("missed fault not on third miss");
    chk_busoff_stop: assert property (@(posedge hclk) disable iff (!hresetn)
        can_bus_off |=> !can_traffic_ff)
        else $error("traffic not stopped at bus-off");
    chk_busoff_mask: assert property (@(posedge hclk) disable iff (!hresetn)
        busoff_mask_ff && !status_ff[dmfm_pkg::BIT_BUSOFF] |=> !status_ff[dmfm_pkg::BIT_BUSOFF])
        else $error("masked bus-off latched");
    chk_fault_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (status_ff != 6'h00) && (clr_bits == 6'h00) |=> (status_ff != 6'h00) && !drive_enable_ff)
        else $error("fault dropped without clear");
endmodule
`default_nettype wire

/* logic/dmfm_pkg.sv */
/*
 Package for the drive motion fault monitor: register map, fault numbers, field
 positions, reset values and timing counts.
 Assumes a 50 MHz hclk and a 32-bit AHB-Lite register bus.
*/
package dmfm_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_CONT_CUR = 8'h0C;
    localparam logic [7:0] ADDR_CUR_CEIL = 8'h10;
    localparam logic [7:0] ADDR_LOW_SPEED = 8'h14;
    localparam logic [7:0] ADDR_STALL_LIM = 8'h18;
    localparam logic [7:0] ADDR_VEL_LIM = 8'h1C;
    localparam logic [7:0] ADDR_ACC_LIM = 8'h20;
    localparam logic [7:0] ADDR_CMD_PERIOD = 8'h24;
    localparam logic [7:0] ADDR_FAULT_CODE = 8'h28;
    localparam logic [7:0] ADDR_BUSOFF_OBJ = 8'h2C;
    // ****************************************
    // Fault bit positions
    // ****************************************
    localparam int NFAULT = 6;
    localparam int BIT_STALL = 0;
    localparam int BIT_VEL = 1;
    localparam int BIT_ACC = 2;
    localparam int BIT_CABLE = 3;
    localparam int BIT_MISSED = 4;
    localparam int BIT_BUSOFF = 5;
    // ****************************************
    // Fault numbers
    // ****************************************
    localparam logic [7:0] FLT_STALL = 8'h3B;
    localparam logic [7:0] FLT_VEL = 8'h1E;
    localparam logic [7:0] FLT_ACC = 8'h42;
    localparam logic [7:0] FLT_CABLE = 8'h41;
    localparam logic [7:0] FLT_MISSED = 8'h45;
    localparam logic [7:0] FLT_BUSOFF = 8'h58;
    // ****************************************
    // Reset values and counts
    // ****************************************
    localparam logic [15:0] RST_CONT_CUR = 16'h0400;
    localparam logic [15:0] RST_CUR_CEIL = 16'h0800;
    localparam logic [15:0] RST_LOW_SPEED = 16'h0010;
    localparam logic [31:0] RST_STALL_LIM = 32'h0000_C350;
    localparam logic [15:0] RST_VEL_LIM = 16'h1000;
    localparam logic [15:0] RST_ACC_LIM = 16'h0100;
    localparam logic [31:0] RST_CMD_PERIOD = 32'h0000_C350;
    localparam logic [1:0] MISS_LIMIT = 2'h3;
    // Ceiling scale: 0.9 = 9/10
    localparam logic [4:0] CEIL_NUM = 5'h09;
    localparam logic [4:0] CEIL_DEN = 5'h0A;
endpackage

/* logic/dmfm_persist_timer.sv */
/*
 Persistence timer: counts cycles while a condition holds, fires once past limit.
 Assumes limit stable while counting.
*/
`timescale 1ns/100ps
`default_nettype none
module dmfm_persist_timer (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Condition
    input wire logic cond,
    input wire logic [31:0] limit,
    // Result
    output logic expired
);
    logic [31:0] cnt_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= 32'h0000_0000;
        end else if (!cond) begin
            cnt_ff <= 32'h0000_0000;
        end else if (cnt_ff <= limit) begin
            cnt_ff <= cnt_ff + 32'h0000_0001;
        end
    end

    assign expired = cond && (cnt_ff > limit);
endmodule
`default_nettype wire

/* logic/dmfm_cmd_check.sv */
/*
 Target command checker: derives step velocity and its change from successive
 targets and flags a command that breaks the velocity or acceleration limit.
 Assumes one target per command period.
*/
`timescale 1ns/100ps
`default_nettype none
module dmfm_cmd_check (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Command
    input wire logic cmd_valid,
    input wire logic [31:0] cmd_target,
    input wire logic [15:0] vel_limit,
    input wire logic [15:0] acc_limit,
    // Verdict
    output logic vel_bad,
    output logic acc_bad,
    output logic accepted
);
    logic [31:0] last_pos_ff;
    logic signed [31:0] last_vel_ff;
    logic primed_ff;
    logic signed [31:0] step;
    logic signed [31:0] dvel;
    logic [31:0] step_abs;
    logic [31:0] dvel_abs;

    always_comb begin
        step = $signed(cmd_target - last_pos_ff);
        dvel = step - last_vel_ff;
        step_abs = step[31] ? 32'(-step) : 32'(step);
        dvel_abs = dvel[31] ? 32'(-dvel) : 32'(dvel);
    end

    assign vel_bad = cmd_valid && primed_ff && (step_abs > {16'h0000, vel_limit});
    assign acc_bad = cmd_valid && primed_ff && !vel_bad && (dvel_abs > {16'h0000, acc_limit});
    assign accepted = cmd_valid && !vel_bad && !acc_bad;

    // Rejected targets leave the reference untouched
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_pos_ff <= 32'h0000_0000;
            last_vel_ff <= 32'sh0000_0000;
            primed_ff <= 1'b0;
        end else if (accepted) begin
            last_pos_ff <= cmd_target;
            last_vel_ff <= primed_ff ? step : 32'sh0000_0000;
            primed_ff <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* verif/dmfm_ctl_model.sv */
/*
 Fieldbus controller model: sends one target every GAP cycles, stepping from the last accepted target.
 Assumes the drive answers an accepted command with cmd_accept one cycle later.
*/
`timescale 1ns/100ps
`default_nettype none
module dmfm_ctl_model #(
    parameter int GAP = 10
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bench control
    input wire logic run,
    input wire logic drop_link,
    input wire logic [31:0] step,
    // Drive side
    input wire logic cmd_accept,
    output logic cmd_valid,
    output logic [31:0] cmd_target,
    output logic cable_present
);
    logic [31:0] ref_ff;
    logic [31:0] sent_ff;
    logic [7:0] gap_ff;
    assign cable_present = !drop_link;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_ff <= 8'h00;
            cmd_valid <= 1'b0;
            cmd_target <= 32'h0;
            sent_ff <= 32'h0;
        end else begin
            gap_ff <= gap_ff + 8'h01;
            cmd_valid <= 1'b0;
            cmd_target <= ~cmd_target;
            if (run && !drop_link && gap_ff >= 8'(GAP - 1)) begin
                gap_ff <= 8'h00;
                cmd_valid <= 1'b1;
                cmd_target <= ref_ff + step;
                sent_ff <= ref_ff + step;
            end
        end
    end
    // Only accepted targets move the reference
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_ff <= 32'h0;
        end else if (cmd_accept) begin
            ref_ff <= sent_ff;
        end
    end
endmodule
`default_nettype wire

/* verif/drive_motion_fault_monitor_tb_top.sv */
/*
 Self-checking bench for the drive motion fault monitor, with a fieldbus controller model.
 Assumes the package, design files and controller model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module drive_motion_fault_monitor_tb_top;
    // ****************************************
    // Signals
    // ****************************************
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, can_bus_off = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, cmd_target;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, cmd_valid, cable_present, cmd_accept;
    logic [15:0] meas_current = 16'h0, meas_velocity = 16'h0;
    logic drive_enable, active_disable, can_traffic_en, irq;
    logic [7:0] fault_code;
    logic run = 1'b0, drop_link = 1'b0, rnd_on = 1'b0, rd_dphase = 1'b0;
    logic [31:0] step = 32'h40;
    logic [31:0] seed = 32'h0000_DBFC;
    logic [71:0] note_q[$];
    int n_fail = 0, n_checks = 0, cycles = 0, n_acc = 0, a0 = 0;
    logic [7:0] ra[10] = '{dmfm_pkg::ADDR_CONT_CUR, dmfm_pkg::ADDR_CUR_CEIL, dmfm_pkg::ADDR_LOW_SPEED,
        dmfm_pkg::ADDR_STALL_LIM, dmfm_pkg::ADDR_VEL_LIM, dmfm_pkg::ADDR_ACC_LIM, dmfm_pkg::ADDR_CMD_PERIOD,
        dmfm_pkg::ADDR_STATUS, dmfm_pkg::ADDR_FAULT_CODE, 8'h40};
    logic [31:0] rv[10] = '{{16'h0, dmfm_pkg::RST_CONT_CUR}, {16'h0, dmfm_pkg::RST_CUR_CEIL},
        {16'h0, dmfm_pkg::RST_LOW_SPEED}, dmfm_pkg::RST_STALL_LIM, {16'h0, dmfm_pkg::RST_VEL_LIM},
        {16'h0, dmfm_pkg::RST_ACC_LIM}, dmfm_pkg::RST_CMD_PERIOD, 32'h0, 32'h0, 32'h0};
    always #10 hclk = ~hclk;
    dmfm_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .meas_current(meas_current), .meas_velocity(meas_velocity), .cmd_valid(cmd_valid),
        .cmd_target(cmd_target), .cable_present(cable_present), .can_bus_off(can_bus_off),
        .drive_enable(drive_enable), .active_disable(active_disable), .can_traffic_en(can_traffic_en),
        .cmd_accept(cmd_accept), .fault_code(fault_code), .irq(irq));
    dmfm_ctl_model ctl (.hclk(hclk), .hresetn(hresetn), .run(run), .drop_link(drop_link), .step(step),
        .cmd_accept(cmd_accept), .cmd_valid(cmd_valid), .cmd_target(cmd_target), .cable_present(cable_present));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk_out(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_word(input logic [71:0] n, input logic [31:0] got);
        n_checks++;
        if ((got & n[63:32]) !== n[31:0]) begin
            n_fail++;
            $display("BAD read at %h expected %h seen %h", n[71:64], n[31:0], got & n[63:32]);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        note_q.push_back({a, m, exp & m});
        bus(a, 1'b0, 32'h0);
    endtask
    task automatic wait_drop(input int lim);
        int k;
        k = 0;
        while (drive_enable !== 1'b0 && k < lim) begin
            @(posedge hclk);
            k++;
        end
        @(posedge hclk);
    endtask
    task automatic fault(input int b, input logic [7:0] code);
        rd(dmfm_pkg::ADDR_STATUS, 32'h1 << b, 32'h1 << b);
        rd(dmfm_pkg::ADDR_FAULT_CODE, {24'h0, code}, 32'hFF);
        chk_out("fault_code", code, fault_code);
        chk_out("drive_enable", 8'h0, {7'h0, drive_enable});
        chk_out("active_disable", {7'h0, b != dmfm_pkg::BIT_STALL}, {7'h0, active_disable});
        chk_out("irq", 8'h1, {7'h0, irq});
    endtask
    task automatic recover();
        bus(dmfm_pkg::ADDR_STATUS, 1'b1, 32'h3F);
        rd(dmfm_pkg::ADDR_STATUS, 32'h0, 32'h3F);
        rd(dmfm_pkg::ADDR_FAULT_CODE, 32'h0, 32'hFF);
        repeat (2) @(posedge hclk);
        chk_out("drive_enable", 8'h1, {7'h0, drive_enable});
        chk_out("irq", 8'h0, {7'h0, irq});
    endtask
    task automatic stall_try(input logic [15:0] cur, input logic [15:0] vel, input int n);
        @(posedge hclk);
        meas_current <= cur;
        meas_velocity <= vel;
        repeat (n) @(posedge hclk);
        meas_current <= 16'h0;
        repeat (3) @(posedge hclk);
        chk_out("drive_enable", 8'h1, {7'h0, drive_enable});
    endtask
    // ****************************************
    // Result watcher, random samples, timeout
    // ****************************************
    always @(posedge hclk) begin
        if (cmd_accept === 1'b1) n_acc <= n_acc + 1;
        if (rd_dphase && hreadyout === 1'b1) begin
            chk_word(note_q.pop_front(), hrdata);
            chk_out("hresp", 8'h0, {7'h0, hresp});
        end
        rd_dphase <= hreadyout ? (hsel && htrans[1] && !hwrite) : rd_dphase;
    end
    always @(posedge hclk) begin
        if (rnd_on) begin
            seed <= xorshift(seed);
            meas_current <= {6'h0, seed[9:0]};
            meas_velocity <= seed[31:16];
        end
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            conclude();
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge hclk);
        chk_out("traffic_en in reset", 8'h1, {7'h0, can_traffic_en});
        chk_out("drive_enable in reset", 8'h0, {7'h0, drive_enable});
        hresetn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd(ra[i], rv[i], 32'hFFFF_FFFF);
        end
        bus(dmfm_pkg::ADDR_STALL_LIM, 1'b1, 32'h14);
        bus(dmfm_pkg::ADDR_CMD_PERIOD, 1'b1, 32'h28);
        bus(dmfm_pkg::ADDR_MASK, 1'b1, 32'h3F);
        bus(dmfm_pkg::ADDR_CTRL, 1'b1, 32'h1);
        run <= 1'b1;
        rnd_on <= 1'b1;
        repeat (60) @(posedge hclk);
        chk_out("drive_enable", 8'h1, {7'h0, drive_enable});
        $display("test reset and setup done");
        rnd_on <= 1'b0;
        stall_try(16'h0733, 16'h0005, 40);
        stall_try(16'h0800, 16'h0010, 40);
        stall_try(16'h0734, 16'h0005, 10);
        meas_current <= 16'h0734;
        wait_drop(40);
        meas_current <= 16'h0;
        fault(dmfm_pkg::BIT_STALL, dmfm_pkg::FLT_STALL);
        recover();
        rnd_on <= 1'b1;
        $display("test stall done");
        step <= 32'h1001;
        wait_drop(40);
        step <= 32'h40;
        fault(dmfm_pkg::BIT_VEL, dmfm_pkg::FLT_VEL);
        recover();
        step <= 32'h140;
        a0 = n_acc;
        repeat (40) @(posedge hclk);
        chk_out("accepts", 8'h4, 8'(n_acc - a0));
        chk_out("drive_enable", 8'h1, {7'h0, drive_enable});
        step <= 32'h241;
        wait_drop(40);
        step <= 32'h140;
        fault(dmfm_pkg::BIT_ACC, dmfm_pkg::FLT_ACC);
        recover();
        step <= 32'h40;
        repeat (40) @(posedge hclk);
        chk_out("drive_enable", 8'h1, {7'h0, drive_enable});
        $display("test command limits done");
        drop_link <= 1'b1;
        wait_drop(20);
        bus(dmfm_pkg::ADDR_MASK, 1'b1, 32'h0);
        repeat (2) @(posedge hclk);
        chk_out("irq masked", 8'h0, {7'h0, irq});
        bus(dmfm_pkg::ADDR_MASK, 1'b1, 32'h3F);
        repeat (2) @(posedge hclk);
        fault(dmfm_pkg::BIT_CABLE, dmfm_pkg::FLT_CABLE);
        drop_link <= 1'b0;
        repeat (5) @(posedge hclk);
        rd(dmfm_pkg::ADDR_STATUS, 32'h8, 32'h8);
        recover();
        $display("test cable done");
        run <= 1'b0;
        repeat (85) @(posedge hclk);
        run <= 1'b1;
        repeat (30) @(posedge hclk);
        run <= 1'b0;
        repeat (85) @(posedge hclk);
        chk_out("drive_enable", 8'h1, {7'h0, drive_enable});
        wait_drop(150);
        fault(dmfm_pkg::BIT_MISSED, dmfm_pkg::FLT_MISSED);
        recover();
        run <= 1'b1;
        $display("test missed commands done");
        bus(dmfm_pkg::ADDR_BUSOFF_OBJ, 1'b1, 32'h1);
        can_bus_off <= 1'b1;
        repeat (3) @(posedge hclk);
        chk_out("traffic_en", 8'h0, {7'h0, can_traffic_en});
        rd(dmfm_pkg::ADDR_STATUS, 32'h0, 32'h20);
        chk_out("drive_enable", 8'h1, {7'h0, drive_enable});
        can_bus_off <= 1'b0;
        repeat (3) @(posedge hclk);
        chk_out("traffic_en", 8'h1, {7'h0, can_traffic_en});
        bus(dmfm_pkg::ADDR_BUSOFF_OBJ, 1'b1, 32'h0);
        can_bus_off <= 1'b1;
        wait_drop(20);
        fault(dmfm_pkg::BIT_BUSOFF, dmfm_pkg::FLT_BUSOFF);
        bus(dmfm_pkg::ADDR_STATUS, 1'b1, 32'h20);
        rd(dmfm_pkg::ADDR_STATUS, 32'h20, 32'h20);
        can_bus_off <= 1'b0;
        recover();
        $display("test bus-off done");
        conclude();
    end
endmodule
`default_nettype wire
